/* File: design/eas_pkg.sv */
// package of constants and types for the extended arithmetic sequencer
`default_nettype none
package eas_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] ADDR_INSTR   = 8'h00;
    localparam logic [7:0] ADDR_PRIMARY = 8'h04;
    localparam logic [7:0] ADDR_LOW     = 8'h08;
    localparam logic [7:0] ADDR_TALLY   = 8'h0C;
    localparam logic [7:0] ADDR_OPERAND = 8'h10;
    localparam logic [7:0] ADDR_STATUS  = 8'h14;

    // status register field positions
    localparam int ST_BUSY    = 0;
    localparam int ST_LINK    = 1;
    localparam int ST_POL     = 2;
    localparam int ST_EVT_LSB = 8;

    // instruction bit numbers, bit 0 is the most significant of 18
    localparam int IB_SIGN_TO_LINK = 4;
    localparam int IB_CLR_LOW      = 5;
    localparam int IB_CAPTURE_SIGN = 6;
    localparam int IB_MERGE_LOW    = 7;
    localparam int IB_CLR_PRIMARY  = 8;
    localparam int IB_INVERT_LOW   = 15;
    localparam int IB_OR_LOW       = 16;
    localparam int IB_OR_TALLY     = 17;

    // operation class, instruction bits 9 to 11
    localparam logic [2:0] CLS_SETUP      = 3'h0;
    localparam logic [2:0] CLS_PRODUCT    = 3'h1;
    localparam logic [2:0] CLS_UNUSED     = 3'h2;
    localparam logic [2:0] CLS_QUOTIENT   = 3'h3;
    localparam logic [2:0] CLS_ALIGN      = 3'h4;
    localparam logic [2:0] CLS_PAIR_RIGHT = 3'h5;
    localparam logic [2:0] CLS_PAIR_LEFT  = 3'h6;
    localparam logic [2:0] CLS_WORD_LEFT  = 3'h7;

    // one-hot event time counter codes
    localparam logic [5:0] EVT_IDLE = 6'h00;
    localparam logic [5:0] EVT_A    = 6'h01;
    localparam logic [5:0] EVT_B    = 6'h02;
    localparam logic [5:0] EVT_C    = 6'h04;
    localparam logic [5:0] EVT_D    = 6'h08;
    localparam logic [5:0] EVT_E    = 6'h10;
    localparam logic [5:0] EVT_F    = 6'h20;

    // reset values
    localparam logic [17:0] WORD_RST  = 18'h00000;
    localparam logic [5:0]  TALLY_RST = 6'h00;

    typedef struct packed {
        logic [17:0] instr;
        logic [17:0] primary;
        logic [17:0] low;
        logic [17:0] operand;
        logic [5:0]  tally;
        logic [5:0]  evt;
        logic        link;
        logic        pol;
        logic        opsign;
        logic        wr_pend;
        logic [7:0]  waddr;
        logic [31:0] rdata;
    } eas_state_t;

    // pick an instruction bit by its numbering from the top
    function automatic logic eas_ib(input logic [17:0] w, input int k);
        return w[17-k];
    endfunction : eas_ib
endpackage : eas_pkg
`default_nettype wire

/* File: design/eas_seq.sv */
// extended arithmetic sequencer with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module eas_seq
    import eas_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic             busy
);
    eas_state_t s_r;
    eas_state_t s_nxt;

    logic [2:0]  cls;
    logic        setup;
    logic        signed_op;
    logic        muldiv;
    logic        stop;
    logic        accept;
    logic        wr_ok;
    logic        ovf;
    logic [18:0] sum;
    logic [18:0] rem;
    logic [18:0] diff;
    logic [35:0] pair;
    logic [31:0] rval;
    logic [31:0] status;

    assign cls       = s_r.instr[8:6];
    assign setup     = (cls == CLS_SETUP);
    assign signed_op = eas_ib(s_r.instr, IB_CAPTURE_SIGN);
    assign muldiv    = (cls == CLS_PRODUCT) || (cls == CLS_QUOTIENT);
    assign busy      = (s_r.evt != EVT_IDLE);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = s_r.rdata;
    assign accept    = hsel && hready && htrans[1];
    // register writes land only while idle so they never race the sequencer
    assign wr_ok     = s_r.wr_pend && !busy;

    assign sum  = {1'b0, s_r.primary} + (s_r.low[0] ? {1'b0, s_r.operand} : 19'h00000);
    assign rem  = {s_r.primary, s_r.low[17]};
    assign diff = rem - {1'b0, s_r.operand};
    assign pair = {s_r.primary, s_r.low};

    // quotient would not fit: signed needs {pri,low} < operand<<17
    always_comb begin
        if (signed_op) begin
            ovf = (rem >= {1'b0, s_r.operand});
        end else begin
            ovf = (s_r.primary >= s_r.operand);
        end
    end

    // normalize stops as soon as the two top primary bits differ
    assign stop = (s_r.tally == TALLY_RST)
                  || ((cls == CLS_ALIGN) && (s_r.primary[17] != s_r.primary[16]));

    // status word built from the field positions so software and logic agree on layout
    always_comb begin
        status                  = 32'h00000000;
        status[ST_BUSY]         = busy;
        status[ST_LINK]         = s_r.link;
        status[ST_POL]          = s_r.pol;
        status[ST_EVT_LSB +: 6] = s_r.evt;
    end

    always_comb begin
        unique case (haddr[7:0])
            ADDR_INSTR:   rval = {14'h0000, s_r.instr};
            ADDR_PRIMARY: rval = {14'h0000, s_r.primary};
            ADDR_LOW:     rval = {14'h0000, s_r.low};
            ADDR_TALLY:   rval = {26'h0000000, s_r.tally};
            ADDR_OPERAND: rval = {14'h0000, s_r.operand};
            ADDR_STATUS:  rval = status;
            default:      rval = 32'h00000000;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        // bus address phase
        if (accept) begin
            s_nxt.wr_pend = hwrite;
            s_nxt.waddr   = haddr[7:0];
            s_nxt.rdata   = hwrite ? 32'h00000000 : rval;
        end else begin
            s_nxt.wr_pend = 1'b0;
        end
        // bus data phase
        if (wr_ok) begin
            unique case (s_r.waddr)
                ADDR_INSTR: begin
                    s_nxt.instr = hwdata[17:0];
                    s_nxt.evt   = EVT_A;
                end
                ADDR_PRIMARY: s_nxt.primary = hwdata[17:0];
                ADDR_LOW:     s_nxt.low     = hwdata[17:0];
                ADDR_OPERAND: s_nxt.operand = hwdata[17:0];
                ADDR_STATUS:  s_nxt.link    = hwdata[ST_LINK];
                default: ;
            endcase
        end
        // event time sequencing; an all-zero option field changes nothing
        unique case (s_r.evt)
            // idle must keep the start that an instruction write has just set above
            EVT_IDLE: ;
            EVT_A: begin
                if (eas_ib(s_r.instr, IB_SIGN_TO_LINK)) begin
                    s_nxt.link = s_r.primary[17];
                end
                if (signed_op) begin
                    s_nxt.pol = s_r.primary[17];
                    if (muldiv) begin
                        // operand sign arrives in the carry, which then restarts clear
                        s_nxt.opsign = s_r.link;
                        s_nxt.link   = 1'b0;
                    end
                    if (!eas_ib(s_r.instr, IB_MERGE_LOW) && s_r.primary[17]) begin
                        s_nxt.primary = 18'(-s_r.primary);
                    end
                end
                s_nxt.evt = EVT_B;
            end
            EVT_B: begin
                if (eas_ib(s_r.instr, IB_CLR_LOW)) begin
                    s_nxt.low = WORD_RST;
                end
                if (eas_ib(s_r.instr, IB_MERGE_LOW) && !signed_op) begin
                    s_nxt.low = s_nxt.low | s_r.primary;
                end
                if (setup && eas_ib(s_r.instr, IB_INVERT_LOW)) begin
                    s_nxt.low = ~s_nxt.low;
                end
                s_nxt.evt = EVT_C;
            end
            EVT_C: begin
                // clearing here rather than at A lets bit 7 merge the old primary first
                if (eas_ib(s_r.instr, IB_CLR_PRIMARY)) begin
                    s_nxt.primary = WORD_RST;
                end
                if (setup && eas_ib(s_r.instr, IB_OR_LOW)) begin
                    s_nxt.primary = s_nxt.primary | s_r.low;
                end
                if (setup && eas_ib(s_r.instr, IB_OR_TALLY)) begin
                    s_nxt.primary = s_nxt.primary | {12'h000, s_r.tally};
                end
                if (!setup) begin
                    s_nxt.tally = 6'(-s_r.instr[5:0]);
                    if (cls == CLS_UNUSED) begin
                        s_nxt.tally = TALLY_RST;
                    end
                    if ((cls == CLS_QUOTIENT) && ovf) begin
                        s_nxt.link  = 1'b1;
                        s_nxt.tally = TALLY_RST;
                    end
                end
                s_nxt.evt = EVT_D;
            end
            EVT_D: begin
                s_nxt.evt = setup ? EVT_IDLE : EVT_E;
            end
            EVT_E: begin
                if (stop) begin
                    s_nxt.evt = EVT_F;
                end else begin
                    s_nxt.tally = s_r.tally + 6'h01;
                    unique case (cls)
                        CLS_PAIR_RIGHT: begin
                            {s_nxt.primary, s_nxt.low} = {s_r.link, pair[35:1]};
                        end
                        CLS_PAIR_LEFT, CLS_ALIGN: begin
                            {s_nxt.primary, s_nxt.low} = {pair[34:0], s_r.link};
                        end
                        CLS_WORD_LEFT: begin
                            s_nxt.primary = {s_r.primary[16:0], s_r.link};
                        end
                        CLS_PRODUCT: begin
                            // add then shift right, one multiplier bit per step
                            s_nxt.primary = sum[18:1];
                            s_nxt.low     = {sum[0], s_r.low[17:1]};
                        end
                        CLS_QUOTIENT: begin
                            // restoring divide, one quotient bit per step
                            if (!diff[18]) begin
                                s_nxt.primary = diff[17:0];
                            end else begin
                                s_nxt.primary = rem[17:0];
                            end
                            s_nxt.low = {s_r.low[16:0], !diff[18]};
                        end
                        default: ;
                    endcase
                end
            end
            EVT_F: begin
                if (signed_op && muldiv && (s_r.pol != s_r.opsign)) begin
                    if (cls == CLS_PRODUCT) begin
                        {s_nxt.primary, s_nxt.low} = 36'(-pair);
                    end else if (!s_r.link) begin
                        s_nxt.low = 18'(-s_r.low);
                    end
                end
                s_nxt.evt = EVT_IDLE;
            end
            default: s_nxt.evt = EVT_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r.instr   <= WORD_RST;
            s_r.primary <= WORD_RST;
            s_r.low     <= WORD_RST;
            s_r.operand <= WORD_RST;
            s_r.tally   <= TALLY_RST;
            s_r.evt     <= EVT_IDLE;
            s_r.link    <= 1'b0;
            s_r.pol     <= 1'b0;
            s_r.opsign  <= 1'b0;
            s_r.wr_pend <= 1'b0;
            s_r.waddr   <= 8'h00;
            s_r.rdata   <= 32'h00000000;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : eas_seq
`default_nettype wire

/* File: tb/eas_seq_assertions.sv */
// port-level assertions for the extended arithmetic sequencer
`timescale 1ns/1ps
`default_nettype none
module eas_seq_assertions
    import eas_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    input wire logic        busy
);
    logic       wr_q;
    logic [6:0] len_r;
    logic [6:0] exp_r;
    wire logic [2:0] cls = hwdata[8:6];
    wire logic       acc = hsel && hready && htrans[1];

    // normalize and divide may stop early, so only setup, unused and shift lengths are tracked
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q  <= 1'b0;
            len_r <= 7'h00;
            exp_r <= 7'h00;
        end else begin
            wr_q  <= acc && hwrite && haddr[7:0] == ADDR_INSTR;
            len_r <= busy ? len_r + 7'h01 : 7'h00;
            if (wr_q && !busy) begin
                exp_r <= (cls == CLS_SETUP) ? 7'h04 : (cls == CLS_UNUSED) ? 7'h06 :
                         (cls[2] && cls != CLS_ALIGN) ? 7'h06 + {1'b0, hwdata[5:0]} : 7'h00;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence start_s;
        wr_q && !busy;
    endsequence
    sequence rd_s(logic [7:0] a);
        acc && !hwrite && haddr[7:0] == a;
    endsequence

    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    start_busy_a: assert property (start_s |=> busy)
        else $error("instruction did not start");
    setup_len_a: assert property (start_s ##0 cls == CLS_SETUP |=> busy [*4] ##1 !busy)
        else $error("setup length not four");
    long_len_a: assert property (start_s ##0 cls != CLS_SETUP |=> busy [*6])
        else $error("non-setup shorter than six");
    unused_len_a: assert property (start_s ##0 cls == CLS_UNUSED |=> busy [*6] ##1 !busy)
        else $error("unused class length not six");
    step_len_a: assert property ($fell(busy) && exp_r != 7'h00 |-> len_r == exp_r)
        else $error("step count length wrong");
    status_busy_a: assert property (rd_s(ADDR_STATUS) |=> hrdata[ST_BUSY] == $past(busy))
        else $error("status busy bit wrong");
    evt_onehot_a: assert property (rd_s(ADDR_STATUS) |=>
        $onehot0(hrdata[13:8]) && (|hrdata[13:8]) == hrdata[ST_BUSY])
        else $error("event counter not one-hot");
    word_width_a: assert property (acc && !hwrite |=> hrdata[31:18] == 14'h0000)
        else $error("read data wider than a word");
    unmapped_zero_a: assert property (acc && !hwrite && haddr[7:0] > ADDR_STATUS |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : eas_seq_assertions

bind eas_seq eas_seq_assertions u_eas_seq_assertions (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .busy);
`default_nettype wire

/* File: tb/eas_host.sv */
// host processor model: register bus master of the sequencer
`timescale 1ns/1ps
`default_nettype none
module eas_host
    import eas_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hreadyout,
    input  wire logic [31:0] hrdata,
    input  wire logic        busy,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // one single word transfer; read data taken at the edge that ends the data phase
    task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d,
                        output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wr ? d : ~hwdata;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer

    // counts busy cycles; bounded so a stuck sequencer cannot hang the host
    task automatic wait_idle(output int n);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (busy !== 1'b0 && n < 300);
        n--;
    endtask : wait_idle

    task automatic issue(input logic [17:0] w, input logic [5:0] cnt, output int n);
        logic [31:0] q;
        xfer(ADDR_INSTR, 1'b1, {14'h0, w | {12'h000, cnt}}, q);
        wait_idle(n);
    endtask : issue
endmodule : eas_host
`default_nettype wire

/* File: tb/eas_seq_test.sv */
// self-checking testbench of the extended arithmetic sequencer
`timescale 1ns/1ps
`default_nettype none
module eas_seq_test
    import eas_pkg::*;
;
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        busy;
    int          fails   = 0;
    int          checked = 0;

    always #2.5 hclk = ~hclk;

    eas_seq u_eas_seq (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .busy);
    eas_host u_eas_host (.hclk, .hreadyout, .hrdata, .busy, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        u_eas_host.xfer(a, 1'b0, 32'h0, q);
        chk(q, exp);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_eas_host.xfer(a, 1'b1, d, q);
    endtask : wr

    task automatic op(input logic [17:0] w, input logic [5:0] cnt, input int len);
        int n;
        u_eas_host.issue(w, cnt, n);
        chk(n, len);
    endtask : op

    task automatic t_reset;
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_PRIMARY, 32'h0);
        rd(ADDR_TALLY, 32'h0);
        rd(8'h40, 32'h0);
    endtask : t_reset

    task automatic t_setup;
        wr(ADDR_PRIMARY, 32'h5);
        wr(ADDR_LOW, 32'h30);
        op(18'h34002, 6'h00, 4);
        rd(ADDR_PRIMARY, 32'h35);
        op(18'h34000, 6'h00, 4);
        rd(ADDR_PRIMARY, 32'h35);
        rd(ADDR_LOW, 32'h30);
        op(18'h34004, 6'h00, 4);
        rd(ADDR_LOW, 32'h3FFCF);
        op(18'h35400, 6'h00, 4);
        rd(ADDR_LOW, 32'h35);
        rd(ADDR_PRIMARY, 32'h35);
        op(18'h35000, 6'h00, 4);
        rd(ADDR_LOW, 32'h0);
        wr(ADDR_LOW, 32'h123);
        op(18'h34202, 6'h00, 4);
        rd(ADDR_PRIMARY, 32'h123);
    endtask : t_setup

    task automatic t_leading_bit_align_op;
        wr(ADDR_STATUS, 32'h0);
        wr(ADDR_PRIMARY, 32'h0);
        wr(ADDR_LOW, 32'h3);
        op(18'h34100, 6'h24, 39);
        rd(ADDR_PRIMARY, 32'h18000);
        rd(ADDR_TALLY, 32'h3D);
        op(18'h34201, 6'h00, 4);
        rd(ADDR_PRIMARY, 32'h3D);
    endtask : t_leading_bit_align_op

    task automatic t_shift;
        wr(ADDR_PRIMARY, 32'h8);
        wr(ADDR_LOW, 32'h0);
        op(18'h34140, 6'h03, 9);
        rd(ADDR_PRIMARY, 32'h1);
        wr(ADDR_LOW, 32'h1);
        op(18'h341C0, 6'h02, 8);
        rd(ADDR_PRIMARY, 32'h4);
        rd(ADDR_LOW, 32'h1);
        wr(ADDR_LOW, 32'h20000);
        op(18'h34180, 6'h01, 7);
        rd(ADDR_PRIMARY, 32'h9);
        rd(ADDR_LOW, 32'h0);
        op(18'h34080, 6'h05, 6);
        rd(ADDR_PRIMARY, 32'h9);
        wr(ADDR_PRIMARY, 32'h5);
        wr(ADDR_OPERAND, 32'h3);
        op(18'h340C0, 6'h12, 6);
        rd(ADDR_STATUS, 32'h2);
    endtask : t_shift

    task automatic t_mul;
        int          n;
        logic [31:0] q;
        wr(ADDR_STATUS, 32'h0);
        wr(ADDR_PRIMARY, 32'h2);
        wr(ADDR_OPERAND, 32'h5);
        u_eas_host.xfer(ADDR_INSTR, 1'b1, 32'h35652, q);
        wr(ADDR_PRIMARY, 32'h1234);
        u_eas_host.wait_idle(n);
        chk(n, 22);
        rd(ADDR_PRIMARY, 32'h0);
        rd(ADDR_LOW, 32'hA);
    endtask : t_mul

    task automatic t_abs;
        wr(ADDR_PRIMARY, 32'h3FFFB);
        op(18'h34800, 6'h00, 4);
        rd(ADDR_PRIMARY, 32'h5);
        rd(ADDR_STATUS, 32'h4);
        wr(ADDR_PRIMARY, 32'h3FFFB);
        op(18'h36800, 6'h00, 4);
        rd(ADDR_PRIMARY, 32'h5);
        rd(ADDR_STATUS, 32'h6);
    endtask : t_abs

    // divisor sign comes in the carry; unlike signs negate the quotient at F
    task automatic t_sdiv;
        wr(ADDR_STATUS, 32'h2);
        wr(ADDR_PRIMARY, 32'h0);
        wr(ADDR_LOW, 32'h6);
        wr(ADDR_OPERAND, 32'h3);
        op(18'h348C0, 6'h12, 24);
        rd(ADDR_LOW, 32'h3FFFE);
        rd(ADDR_PRIMARY, 32'h0);
        rd(ADDR_STATUS, 32'h0);
    endtask : t_sdiv

    task automatic test_done;
        $display("fails %0d checked %0d", fails, checked);
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_setup;
        t_leading_bit_align_op;
        t_shift;
        t_mul;
        t_abs;
        t_sdiv;
        test_done;
    end

    // the run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        test_done;
    end
endmodule : eas_seq_test
`default_nettype wire
